// file: logic/tccu_unit.sv
// Capture/compare unit with its 16-bit timer, AXI4-Lite register slave and interrupt
// Assumes an asynchronous external pin; the pin input is synchronised here
// What this block does
// - On a selected capture event copy the full 16-bit timer count into value register.
// - Capture event: falling edge, rising edge, every 4th or 16th rising edge.
// - Every capture sets the sticky event flag; only software clears it.
// - A new capture overwrites the value register even if unread.
// - With pin as output, a latch write changing the level may capture.
// - Mode change may raise spurious capture; software masks then clears flag.
// - Prescaler counter cleared while off or not capturing, and after reset.
// - Switching between prescale settings keeps the counter; may raise an interrupt.
// - Compare mode matches value against timer, then sets, clears, toggles or keeps pin.
// - Every compare match sets the event flag together with the pin action.
// - Writing zero to control forces the compare output latch low.
// - Software-interrupt compare mode leaves the pin alone, only sets the flag.
// - Trigger mode match resets the timer, making value a 16-bit period.
// - Trigger also starts a conversion, only when the converter is enabled.
// - The trigger's timer reset does not set the timer overflow flag.
// - Control register at index 17h, mode in low four bits, resets to zero.
`include "tccu_params.svh"

module tccu_unit
    import tccu_pkg::*;
#(
    parameter int TIMER_WIDTH = 16
)
(
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // AXI4-Lite write
    input  wire logic [`TCCU_ADDR_BITS-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`TCCU_ADDR_BITS-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Capture/compare pin
    input  wire logic                        pinIn,
    output logic                             pinOut,
    output logic                             pinOutEnable_n,
    // Converter and interrupt
    output logic                             convertStart,
    output logic                             irq
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    tccu_control_type         control_q;
    logic [TIMER_WIDTH-1:0]   value_q;
    logic [TIMER_WIDTH-1:0]   timer_q;
    logic [`TCCU_STAT_BITS-1:0] status_q;
    logic [`TCCU_STAT_BITS-1:0] mask_q;
    logic [7:0]               port_q;
    logic                     convEnable_q;
    logic                     cmpLatch_q;
    logic [3:0]               prescale_q;
    logic                     pinSync1_q;
    logic                     pinSync2_q;
    logic                     pinLast_q;
    logic                     awHeld_q;
    logic                     wHeld_q;
    logic [`TCCU_ADDR_BITS-1:0] awAddr_q;
    logic [31:0]              wData_q;
    logic [3:0]               wStrb_q;

    // ----------------------------------------
    // Write channel decode
    // ----------------------------------------
    logic                     wrFire;
    logic [7:0]               wrIdx;
    logic                     wrByte0;
    logic                     wrHit;
    logic                     wrControl;
    logic                     wrValueLow;
    logic                     wrValueHigh;
    logic                     wrStatus;
    logic                     wrMask;
    logic                     wrPort;
    logic                     wrTimerLow;
    logic                     wrTimerHigh;
    logic                     wrConv;
    logic [7:0]               wrByte;

    assign wrFire      = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrIdx       = awAddr_q[9:2];
    assign wrByte0     = wrFire && wStrb_q[0] && (awAddr_q[1:0] == 2'h0);
    assign wrByte      = wData_q[7:0];
    assign wrControl   = wrByte0 && (wrIdx == `TCCU_IDX_CONTROL);
    assign wrValueLow  = wrByte0 && (wrIdx == `TCCU_IDX_VALUE_LOW);
    assign wrValueHigh = wrByte0 && (wrIdx == `TCCU_IDX_VALUE_HIGH);
    assign wrStatus    = wrByte0 && (wrIdx == `TCCU_IDX_STATUS);
    assign wrMask      = wrByte0 && (wrIdx == `TCCU_IDX_MASK);
    assign wrPort      = wrByte0 && (wrIdx == `TCCU_IDX_PORT);
    assign wrTimerLow  = wrByte0 && (wrIdx == `TCCU_IDX_TIMER_LOW);
    assign wrTimerHigh = wrByte0 && (wrIdx == `TCCU_IDX_TIMER_HIGH);
    assign wrConv      = wrByte0 && (wrIdx == `TCCU_IDX_CONVERTER);
    assign wrHit       = (wrIdx >= `TCCU_IDX_VALUE_LOW) && (wrIdx <= `TCCU_IDX_CONVERTER);

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic [3:0]               mode;
    logic                     isCapture;
    logic                     isCompare;
    logic                     isTrigger;

    assign mode      = control_q.mode;
    assign isCapture = (mode == `TCCU_MODE_FALL) || (mode == `TCCU_MODE_RISE)
                    || (mode == `TCCU_MODE_RISE4) || (mode == `TCCU_MODE_RISE16);
    assign isCompare = (mode == `TCCU_MODE_TOGGLE) || (mode[3:2] == 2'b10);
    assign isTrigger = (mode == `TCCU_MODE_TRIGGER);

    // ----------------------------------------
    // Capture path
    // ----------------------------------------
    // Pin level seen by capture: driven latch level when the pin is an output
    logic                     pinLevel;
    logic                     riseEdge;
    logic                     fallEdge;
    logic                     prescaleHit;
    logic                     captureEvent;
    logic [3:0]               prescaleNext;

    assign pinLevel     = port_q[`TCCU_PORT_DIR_IN] ? pinSync2_q : pinOut;
    assign riseEdge     = pinLevel && !pinLast_q;
    assign fallEdge     = !pinLevel && pinLast_q;
    assign prescaleHit  = (mode == `TCCU_MODE_RISE4) ? (prescale_q[1:0] == 2'h3)
                                                     : (prescale_q == 4'hf);
    assign captureEvent = ((mode == `TCCU_MODE_FALL) && fallEdge)
                       || ((mode == `TCCU_MODE_RISE) && riseEdge)
                       || (((mode == `TCCU_MODE_RISE4) || (mode == `TCCU_MODE_RISE16))
                           && riseEdge && prescaleHit);
    // Counter kept across prescale changes; only leaving capture clears it
    assign prescaleNext = !isCapture ? 4'h0
                        : (riseEdge ? 4'(prescale_q + 4'h1) : prescale_q);

    // ----------------------------------------
    // Compare path
    // ----------------------------------------
    logic                     match;
    logic                     cmpLatchNext;
    logic                     trigger;
    logic                     timerWrap;
    logic [TIMER_WIDTH-1:0]   timerNext;

    assign match = isCompare && (value_q == timer_q);
    assign trigger = match && isTrigger;
    always_comb
    begin
        cmpLatchNext = cmpLatch_q;
        if (wrControl && (wrByte == 8'h00))
        begin
            cmpLatchNext = 1'b0;
        end
        else if (match)
        begin
            unique case (mode)
                `TCCU_MODE_SET:    cmpLatchNext = 1'b1;
                `TCCU_MODE_CLEAR:  cmpLatchNext = 1'b0;
                `TCCU_MODE_TOGGLE: cmpLatchNext = !cmpLatch_q;
                default:           cmpLatchNext = cmpLatch_q;
            endcase
        end
    end

    // Timer runs synchronously to core_clk only, so no asynchronous counting mode
    assign timerWrap = (timer_q == {TIMER_WIDTH{1'b1}});
    always_comb
    begin
        timerNext = TIMER_WIDTH'(timer_q + 1'b1);
        if (trigger)
        begin
            timerNext = '0;
        end
        else if (wrTimerLow)
        begin
            timerNext = {timer_q[TIMER_WIDTH-1:8], wrByte};
        end
        else if (wrTimerHigh)
        begin
            timerNext = {wrByte, timer_q[7:0]};
        end
    end

    // ----------------------------------------
    // Status, set wins over clear
    // ----------------------------------------
    tccu_event_type           events;
    logic [`TCCU_STAT_BITS-1:0] statusSet;
    logic [`TCCU_STAT_BITS-1:0] statusNext;
    logic [TIMER_WIDTH-1:0]   valueNext;

    assign events.captured = isCapture && captureEvent;
    assign events.matched  = match;
    assign events.trigger  = trigger && convEnable_q;
    // Overflow only from natural wrap; trigger reset does not count
    assign statusSet[`TCCU_STAT_EVENT]    = events.captured || events.matched;
    assign statusSet[`TCCU_STAT_OVERFLOW] = timerWrap && !trigger && !wrTimerLow
                                         && !wrTimerHigh;
    assign statusSet[`TCCU_STAT_CONVERT]  = events.trigger;
    assign statusNext = (status_q & ~(wrStatus ? wrByte[`TCCU_STAT_BITS-1:0] : '0))
                      | statusSet;
    assign valueNext  = events.captured ? timer_q
                      : wrValueLow  ? {value_q[TIMER_WIDTH-1:8], wrByte}
                      : wrValueHigh ? {wrByte, value_q[7:0]} : value_q;

    // ----------------------------------------
    // Core registers
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            control_q    <= `TCCU_CONTROL_RESET;
            value_q      <= '0;
            timer_q      <= '0;
            status_q     <= '0;
            mask_q       <= '0;
            port_q       <= `TCCU_PORT_RESET;
            convEnable_q <= 1'b0;
            cmpLatch_q   <= 1'b0;
            prescale_q   <= 4'h0;
            pinSync1_q   <= 1'b0;
            pinSync2_q   <= 1'b0;
            pinLast_q    <= 1'b0;
        end
        else
        begin
            control_q    <= wrControl ? wrByte : control_q;
            value_q      <= valueNext;
            timer_q      <= timerNext;
            status_q     <= statusNext;
            mask_q       <= wrMask ? wrByte[`TCCU_STAT_BITS-1:0] : mask_q;
            port_q       <= wrPort ? {6'h0, wrByte[1:0]} : port_q;
            convEnable_q <= wrConv ? wrByte[0] : convEnable_q;
            cmpLatch_q   <= cmpLatchNext;
            prescale_q   <= prescaleNext;
            pinSync1_q   <= pinIn;
            pinSync2_q   <= pinSync1_q;
            pinLast_q    <= pinLevel;
        end
    end

    // ----------------------------------------
    // Pin, converter and interrupt outputs
    // ----------------------------------------
    // Compare latch owns the pin in compare modes, port latch otherwise
    logic                     pinOutNext;

    assign pinOutNext = isCompare ? cmpLatchNext : port_q[`TCCU_PORT_LATCH];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pinOut         <= 1'b0;
            pinOutEnable_n <= 1'b1;
            convertStart   <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            pinOut         <= pinOutNext;
            pinOutEnable_n <= wrPort ? wrByte[`TCCU_PORT_DIR_IN]
                                     : port_q[`TCCU_PORT_DIR_IN];
            convertStart   <= events.trigger;
            irq            <= |(statusNext & (wrMask ? wrByte[`TCCU_STAT_BITS-1:0]
                                                     : mask_q));
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic [7:0]               rdIdx;
    logic                     rdHit;
    logic [31:0]              rdWord;

    assign rdIdx = s_axi_araddr[9:2];
    assign rdHit = (rdIdx >= `TCCU_IDX_VALUE_LOW) && (rdIdx <= `TCCU_IDX_CONVERTER);
    always_comb
    begin
        rdWord = 32'h0;
        unique case (rdIdx)
            `TCCU_IDX_CONTROL:    rdWord = {24'h0, control_q};
            `TCCU_IDX_VALUE_LOW:  rdWord = {24'h0, value_q[7:0]};
            `TCCU_IDX_VALUE_HIGH: rdWord = {24'h0, value_q[15:8]};
            `TCCU_IDX_STATUS:     rdWord = {29'h0, status_q};
            `TCCU_IDX_MASK:       rdWord = {29'h0, mask_q};
            `TCCU_IDX_PORT:       rdWord = {24'h0, port_q};
            `TCCU_IDX_TIMER_LOW:  rdWord = {24'h0, timer_q[7:0]};
            `TCCU_IDX_TIMER_HIGH: rdWord = {24'h0, timer_q[15:8]};
            `TCCU_IDX_CONVERTER:  rdWord = {31'h0, convEnable_q};
            default:              rdWord = 32'h0;
        endcase
    end

    // One write and one read at a time; channels held until the response leaves
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h0;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TCCU_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `TCCU_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `TCCU_RESP_OKAY : `TCCU_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdWord;
                s_axi_rresp  <= rdHit ? `TCCU_RESP_OKAY : `TCCU_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: logic/tccu_params.svh
// Offsets, field positions, reset values and mode codes of the capture/compare unit
// Assumes a 32-bit AXI4-Lite register slave; printed offsets are register indices
`ifndef TCCU_PARAMS_SVH
`define TCCU_PARAMS_SVH

// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define TCCU_IDX_CONTROL      8'h17
`define TCCU_IDX_VALUE_LOW    8'h15
`define TCCU_IDX_VALUE_HIGH   8'h16
`define TCCU_IDX_STATUS       8'h18
`define TCCU_IDX_MASK         8'h19
`define TCCU_IDX_PORT         8'h1a
`define TCCU_IDX_TIMER_LOW    8'h1b
`define TCCU_IDX_TIMER_HIGH   8'h1c
`define TCCU_IDX_CONVERTER    8'h1d
`define TCCU_ADDR_BITS        10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TCCU_STAT_EVENT       0
`define TCCU_STAT_OVERFLOW    1
`define TCCU_STAT_CONVERT     2
`define TCCU_STAT_BITS        3
`define TCCU_PORT_LATCH       0
`define TCCU_PORT_DIR_IN      1
`define TCCU_CONTROL_RESET    8'h00
`define TCCU_PORT_RESET       8'h02

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define TCCU_MODE_OFF         4'h0
`define TCCU_MODE_TOGGLE      4'h2
`define TCCU_MODE_FALL        4'h4
`define TCCU_MODE_RISE        4'h5
`define TCCU_MODE_RISE4       4'h6
`define TCCU_MODE_RISE16      4'h7
`define TCCU_MODE_SET         4'h8
`define TCCU_MODE_CLEAR       4'h9
`define TCCU_MODE_SOFT        4'ha
`define TCCU_MODE_TRIGGER     4'hb

`define TCCU_RESP_OKAY        2'b00
`define TCCU_RESP_SLVERR      2'b10

`endif

// file: logic/tccu_pkg.sv
// Types shared by the capture/compare unit
// Assumes tccu_params.svh sits beside it
package tccu_pkg;

    typedef struct packed {
        logic [3:0] top;
        logic [3:0] mode;
    } tccu_control_type;

    typedef struct packed {
        logic        captured;
        logic        matched;
        logic        trigger;
    } tccu_event_type;

endpackage

// file: tb/tccu_pin_model.sv
// Outside source on the capture/compare pin, plus the resolved pin wire
// Assumes the bench calls pulse() only while the pin is an input
module tccu_pin_model
(
    // Clock
    input  wire logic core_clk,
    // Unit side of the pin
    input  wire logic pinOut,
    input  wire logic pinOutEnable_n,
    // Resolved pin level
    output logic      pinLine
);
    timeunit 1ns;
    timeprecision 1ps;

    logic extLevel;

    initial extLevel = 1'b0;

    // Unit wins the wire while its enable is low
    assign pinLine = pinOutEnable_n ? extLevel : pinOut;

    // Levels change just after an edge, in step with the timer clock
    task automatic pulse();
        repeat (4) @(posedge core_clk);
        extLevel <= 1'b1;
        repeat (4) @(posedge core_clk);
        extLevel <= 1'b0;
        // Falling edge needs the synchroniser delay before a capture shows
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// file: tb/tccu_unit_checker.sv
// Handshake and pulse properties of the capture/compare unit
// Assumes it is bound to tccu_unit and sees only its ports
module tccu_unit_checker
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Converter
    input wire logic        convertStart
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    a_no_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than a cycle");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("illegal write response");
    a_convert_pulse: assert property (convertStart |=> !convertStart)
        else $error("conversion start longer than a cycle");
endmodule

bind tccu_unit tccu_unit_checker u_chk (.core_clk, .rst, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .convertStart);

// file: tb/timer_capture_compare_unit_test.sv
// Self-checking bench for the capture/compare unit over its register bus
// Assumes tccu_params.svh on the include path and the pin model beside it
`include "tccu_params.svh"

module timer_capture_compare_unit_test;
    import tccu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0, rst = 1'b1;
    logic [9:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pinLine, pinOut, pinOe_n;
    logic        convertStart, irq;
    logic [1:0]  bresp, rresp;
    int          errTotal = 0, nTests = 0, cyc = 0, convCount = 0;

    always #2.5 core_clk = ~core_clk;

    tccu_unit DUT (.core_clk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pinIn(pinLine), .pinOut(pinOut), .pinOutEnable_n(pinOe_n),
        .convertStart(convertStart), .irq(irq));

    tccu_pin_model pm (.core_clk, .pinOut, .pinOutEnable_n(pinOe_n), .pinLine);

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        cyc++;
        if (convertStart === 1'b1) convCount++;
        if (cyc == 40000)
        begin
            errTotal++;
            stopTest();
        end
    end

    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e)
        begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (!a && awready === 1'b1)
            begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1)
            begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!(a && w));
        // Late bready makes the response wait, so its hold gets checked
        repeat (2) @(posedge core_clk);
        bready <= 1'b1;
        do @(posedge core_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", er, bresp);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er = 2'b00);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        // Late rready makes read data wait, so its hold gets checked
        @(posedge core_clk);
        rready <= 1'b1;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 0;
        chk("rresp", er, rresp);
    endtask

    task automatic wait_stat(input int b);
        logic [31:0] v;
        int k;
        k = 0;
        do begin rd(`TCCU_IDX_STATUS, v); k++; end while (v[b] !== 1'b1 && k < 200);
        chk("status wait", 1, v[b]);
    endtask

    // Prescaler cleared by turning off first; n events for one capture
    task automatic cap(input logic [3:0] m, input int n, input logic [7:0] hb);
        logic [31:0] v;
        wr(`TCCU_IDX_CONTROL, 8'h00);
        wr(`TCCU_IDX_CONTROL, {4'h0, m});
        wr(`TCCU_IDX_STATUS, 8'h01);
        repeat (n - 1) pm.pulse();
        rd(`TCCU_IDX_STATUS, v);
        chk("early capture", 0, v[0]);
        chk("irq idle", 0, irq);
        // Low byte first, so no carry can reach the high byte
        wr(`TCCU_IDX_TIMER_LOW, 8'h00);
        wr(`TCCU_IDX_TIMER_HIGH, hb);
        pm.pulse();
        rd(`TCCU_IDX_STATUS, v);
        chk("capture flag", 1, v[0]);
        chk("irq raised", 1, irq);
        rd(`TCCU_IDX_VALUE_HIGH, v);
        chk("captured high", hb, v);
    endtask

    task automatic cmp(input logic [3:0] m, input logic e);
        wr(`TCCU_IDX_STATUS, 8'h01);
        wr(`TCCU_IDX_TIMER_LOW, 8'h00);
        wr(`TCCU_IDX_TIMER_HIGH, 8'h00);
        wr(`TCCU_IDX_CONTROL, {4'h0, m});
        wait_stat(`TCCU_STAT_EVENT);
        chk("pin after match", e, pinOut);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] v;
        repeat (6) @(posedge core_clk);
        rst <= 0;
        rd(`TCCU_IDX_CONTROL, v);
        chk("control reset", `TCCU_CONTROL_RESET, v);
        rd(`TCCU_IDX_PORT, v);
        chk("port reset", `TCCU_PORT_RESET, v);
        rd(8'h30, v, `TCCU_RESP_SLVERR);
        chk("unmapped read", 0, v);
        wr(8'h30, 8'h5a, `TCCU_RESP_SLVERR);
        $display("test registers done");

        wr(`TCCU_IDX_MASK, 8'h01);
        cap(`TCCU_MODE_FALL, 1, 8'h31);
        cap(`TCCU_MODE_RISE, 1, 8'h42);
        cap(`TCCU_MODE_RISE4, 4, 8'h53);
        cap(`TCCU_MODE_RISE16, 16, 8'h64);
        wr(`TCCU_IDX_PORT, 8'h00);
        wr(`TCCU_IDX_CONTROL, {4'h0, `TCCU_MODE_RISE});
        wr(`TCCU_IDX_STATUS, 8'h01);
        wr(`TCCU_IDX_PORT, 8'h01);
        rd(`TCCU_IDX_STATUS, v);
        chk("latch capture", 1, v[0]);
        $display("test capture done");

        wr(`TCCU_IDX_VALUE_LOW, 8'h60);
        wr(`TCCU_IDX_VALUE_HIGH, 8'h00);
        wr(`TCCU_IDX_CONTROL, 8'h00);
        chk("port latch on pin", 1, pinOut);
        chk("pin driven", 0, pinOe_n);
        cmp(`TCCU_MODE_SET, 1);
        cmp(`TCCU_MODE_CLEAR, 0);
        cmp(`TCCU_MODE_TOGGLE, 1);
        cmp(`TCCU_MODE_SOFT, 1);
        wr(`TCCU_IDX_CONTROL, 8'h00);
        // Soft mode shows the compare latch on the pin without moving it
        wr(`TCCU_IDX_CONTROL, {4'h0, `TCCU_MODE_SOFT});
        chk("latch forced low", 0, pinOut);
        $display("test compare done");

        wr(`TCCU_IDX_VALUE_HIGH, 8'h01);
        wr(`TCCU_IDX_CONVERTER, 8'h01);
        wr(`TCCU_IDX_STATUS, 8'h07);
        convCount = 0;
        cmp(`TCCU_MODE_TRIGGER, 0);
        wait_stat(`TCCU_STAT_CONVERT);
        rd(`TCCU_IDX_TIMER_HIGH, v);
        chk("timer restarted", 0, v);
        rd(`TCCU_IDX_STATUS, v);
        chk("no overflow", 0, v[`TCCU_STAT_OVERFLOW]);
        chk("convert pulses", 1, convCount);
        wr(`TCCU_IDX_CONVERTER, 8'h00);
        wr(`TCCU_IDX_STATUS, 8'h07);
        convCount = 0;
        wait_stat(`TCCU_STAT_EVENT);
        rd(`TCCU_IDX_STATUS, v);
        chk("no conversion", 0, v[`TCCU_STAT_CONVERT]);
        chk("convert idle", 0, convCount);
        $display("test trigger done");
        stopTest();
    end
endmodule
